// ==== rtl/ca_defs.svh ====
`ifndef CA_DEFS_SVH
`define CA_DEFS_SVH

// ==========================================================
// Register byte offsets
`define CA_OFS_CTRL      8'h00
`define CA_OFS_CMODE     8'h04
`define CA_OFS_CNT_LO    8'h08
`define CA_OFS_CNT_HI    8'h0C
`define CA_OFS_IRQ_EN    8'h10
`define CA_OFS_MODE0     8'h20
`define CA_OFS_CAPL0     8'h40
`define CA_OFS_CAPH0     8'h60

// ==========================================================
// Counter control register fields
`define CA_CTRL_OVF      7
`define CA_CTRL_RUN      6

// Counter mode register fields
`define CA_CMODE_WATCHDOG_ENABLE_BIT    6
`define CA_CMODE_SEL_HI  2
`define CA_CMODE_SEL_LO  1
`define CA_CMODE_ECF     0

// Interrupt enable register fields
`define CA_IEN_GLOBAL    7
`define CA_IEN_ARRAY     6

// Module mode register fields
`define CA_MM_COMPARATOR_ENABLE       6
`define CA_MM_MAT        3
`define CA_MM_TOG        2
`define CA_MM_PWM        1
`define CA_MM_ECCF       0

// ==========================================================
// Reset values and timing
`define CA_RST_BYTE      8'h00
`define CA_RST_PIN       1'b1
`define CA_OSC_DIV       6
`define CA_WD_MODULE     4

`endif

// ==== rtl/ca_pkg.sv ====
package ca_pkg;
  // Count source select codes
  typedef enum logic [1:0] {
    SRC_OSC_A  = 2'h0,
    SRC_OSC_B  = 2'h1,
    SRC_TMR0   = 2'h2,
    SRC_EXTPIN = 2'h3
  } count_src_t;
  typedef logic [7:0] byte_t;
endpackage

// ==== rtl/counter_array_compare_pwm_watchdog.sv ====
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/100ps
`include "ca_defs.svh"

module counter_array_compare_pwm_watchdog
  import ca_pkg::*;
#(
  parameter int NUM_MOD = 5
) (
  input  wire logic               CLK,              // System clock, 50 MHz
  input  wire logic               RST_N,            // Synchronous reset, active low
  input  wire logic               WB_CYC_I,         // Bus cycle
  input  wire logic               WB_STB_I,         // Bus strobe
  input  wire logic               WB_WE_I,          // Write enable
  input  wire logic [7:0]         WB_ADR_I,         // Byte address
  input  wire logic [3:0]         WB_SEL_I,         // Byte lane selects
  input  wire logic [31:0]        WB_DAT_I,         // Write data
  output logic      [31:0]        WB_DAT_O,         // Read data
  output logic                    WB_ACK_O,         // Acknowledge
  input  wire logic               TIMER0_OVF,       // Timer 0 overflow pulse
  input  wire logic               EXT_COUNT_IN,     // External count pin
  output logic      [NUM_MOD-1:0] MODULE_COMPARE_PIN, // Module output levels
  output logic      [NUM_MOD-1:0] MODULE_COMPARE_OE,  // Module output enables
  output logic                    IRQ,              // Serviceable interrupt request
  output logic                    WD_RESET          // Internal reset pulse
);

  // ==========================================================
  // Register state
  logic             ack_reg;
  logic [31:0]      rdat_reg;
  logic             ovf_reg;
  logic             run_reg;
  logic [NUM_MOD-1:0] flag_reg;
  logic             watchdog_enable_bit_reg;
  logic             ecf_reg;
  count_src_t       src_reg;
  logic             gie_reg;
  logic             aie_reg;
  logic [15:0]      cnt_reg;
  logic [15:0]      cnt_next;
  byte_t            mode_reg [NUM_MOD];
  byte_t            capl_reg [NUM_MOD];
  byte_t            caph_reg [NUM_MOD];
  logic [NUM_MOD-1:0] pin_reg;
  logic             wd_reg;

  // ==========================================================
  // Count source state
  logic [2:0]       pre_reg;
  logic             ext_s1_reg;
  logic             ext_s2_reg;
  logic             ext_s3_reg;
  logic             step_reg;

  // ==========================================================
  // Bus decode
  wire logic        bus_req   = WB_CYC_I & WB_STB_I;
  wire logic        wr_go     = bus_req & WB_WE_I & ack_reg & WB_SEL_I[0];
  wire logic [5:0]  word_idx  = WB_ADR_I[7:2];
  wire logic        hit_ctrl  = (WB_ADR_I == `CA_OFS_CTRL);
  wire logic        hit_cmode = (WB_ADR_I == `CA_OFS_CMODE);
  wire logic        hit_cntl  = (WB_ADR_I == `CA_OFS_CNT_LO);
  wire logic        hit_cnth  = (WB_ADR_I == `CA_OFS_CNT_HI);
  wire logic        hit_ien   = (WB_ADR_I == `CA_OFS_IRQ_EN);
  wire logic        wr_ctrl   = wr_go & hit_ctrl;
  wire logic        wr_cmode  = wr_go & hit_cmode;
  wire logic        wr_cntl   = wr_go & hit_cntl;
  wire logic        wr_cnth   = wr_go & hit_cnth;
  wire logic        wr_ien    = wr_go & hit_ien;
  wire logic [2:0]  mod_sel   = word_idx[2:0];
  wire logic        mod_ok    = (WB_ADR_I[1:0] == 2'h0) && (mod_sel < 3'(NUM_MOD));
  // Each group spans eight words; mod_ok keeps the modules in use
  wire logic        grp_mode  = (WB_ADR_I[7:5] == 3'(`CA_OFS_MODE0 >> 5));
  wire logic        grp_capl  = (WB_ADR_I[7:5] == 3'(`CA_OFS_CAPL0 >> 5));
  wire logic        grp_caph  = (WB_ADR_I[7:5] == 3'(`CA_OFS_CAPH0 >> 5));
  wire byte_t       wbyte     = WB_DAT_I[7:0];

  // ==========================================================
  // Count source selection
  wire logic        pre_end   = (pre_reg == 3'(`CA_OSC_DIV - 1));
  // Pin falls are counted about three cycles late
  wire logic        ext_fall  = ext_s3_reg & ~ext_s2_reg;
  logic             src_tick;

  // Pick the count pulse by the select code
  always_comb begin
    case (src_reg)
      SRC_OSC_A:  src_tick = pre_end;
      SRC_OSC_B:  src_tick = pre_end;
      SRC_TMR0:   src_tick = TIMER0_OVF;
      SRC_EXTPIN: src_tick = ext_fall;
      default:    src_tick = 1'b0;
    endcase
  end

  // Single shared time base for every module
  wire logic        cnt_tick  = run_reg & src_tick;
  wire logic        lo_wrap   = cnt_tick & (cnt_reg[7:0] == 8'hFF);
  wire logic        cnt_roll  = cnt_tick & (cnt_reg == 16'hFFFF);

  // Counter next value, software load wins over counting
  always_comb begin
    cnt_next = cnt_reg;
    if (cnt_tick) begin
      cnt_next = cnt_reg + 16'h0001;
    end
    if (wr_cntl) begin
      cnt_next[7:0] = wbyte;
    end
    if (wr_cnth) begin
      cnt_next[15:8] = wbyte;
    end
  end

  // Oscillator prescaler runs only with the counter
  // Held at zero while stopped, so each run starts a full divide
  always_ff @(posedge CLK) begin
    if (!RST_N || !run_reg || pre_end) begin
      pre_reg <= 3'h0;
    end else begin
      pre_reg <= pre_reg + 3'h1;
    end
  end

  // External pin synchroniser and edge history
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= EXT_COUNT_IN;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  // Counter and step strobe for compare
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cnt_reg  <= 16'h0000;
      step_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      step_reg <= cnt_tick;
    end
  end

  // ==========================================================
  // Per-module compare, pulse and flag logic
  logic [NUM_MOD-1:0] match;
  logic [NUM_MOD-1:0] flag_set;
  logic [NUM_MOD-1:0] flag_irq;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_MOD; gi++) begin : g_mod
      wire logic comparator_enable   = mode_reg[gi][`CA_MM_COMPARATOR_ENABLE];
      wire logic match_enable    = mode_reg[gi][`CA_MM_MAT];
      wire logic toggle_enable    = mode_reg[gi][`CA_MM_TOG];
      wire logic pwm    = mode_reg[gi][`CA_MM_PWM];
      wire logic pwm_on = pwm & comparator_enable;
      wire logic hso_on = toggle_enable & match_enable & comparator_enable;
      wire logic sel_me = mod_ok && (mod_sel == 3'(gi));
      wire logic wr_m   = wr_go & grp_mode & sel_me;
      wire logic wr_l   = wr_go & grp_capl & sel_me;
      wire logic wr_h   = wr_go & grp_caph & sel_me;

      // One strobe in the cycle after the step that reaches the value
      // Compare sees the settled count, never a half-updated one
      assign match[gi]    = step_reg & comparator_enable & (cnt_reg == {caph_reg[gi], capl_reg[gi]});
      assign flag_set[gi] = match[gi] & match_enable;
      assign flag_irq[gi] = flag_reg[gi] & mode_reg[gi][`CA_MM_ECCF];
      assign MODULE_COMPARE_OE[gi] = pwm_on | hso_on;

      // Mode and compare bytes, pulse reload on low byte wrap
      // Reload beats a same-cycle software write to the low byte
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          mode_reg[gi] <= `CA_RST_BYTE;
          capl_reg[gi] <= `CA_RST_BYTE;
          caph_reg[gi] <= `CA_RST_BYTE;
        end else begin
          if (wr_m) begin
            mode_reg[gi] <= {1'b0, wbyte[6:0]};
          end
          if (pwm_on && lo_wrap) begin
            capl_reg[gi] <= caph_reg[gi];
          end else if (wr_l) begin
            capl_reg[gi] <= wbyte;
          end
          if (wr_h) begin
            caph_reg[gi] <= wbyte;
          end
        end
      end

      // Output pin: pulse compare or toggle on match
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          pin_reg[gi] <= `CA_RST_PIN;
        end else if (pwm_on) begin
          pin_reg[gi] <= (cnt_reg[7:0] >= capl_reg[gi]);
        end else if (hso_on && match[gi]) begin
          pin_reg[gi] <= ~pin_reg[gi];
        end
      end
    end
  endgenerate

  assign MODULE_COMPARE_PIN = pin_reg;

  // ==========================================================
  // Control and status registers
  wire logic [NUM_MOD-1:0] flag_keep = wr_ctrl ? WB_DAT_I[NUM_MOD-1:0] : {NUM_MOD{1'b1}};

  // Flags: hardware set wins over a software clear
  // Overflow flag may be written either way by software
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      flag_reg <= '0;
      ovf_reg  <= 1'b0;
      run_reg  <= 1'b0;
    end else begin
      flag_reg <= (flag_reg & flag_keep) | flag_set;
      ovf_reg  <= (wr_ctrl ? WB_DAT_I[`CA_CTRL_OVF] : ovf_reg) | cnt_roll;
      if (wr_ctrl) begin
        run_reg <= WB_DAT_I[`CA_CTRL_RUN];
      end
    end
  end

  // Count mode, watchdog enable and interrupt enables
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      watchdog_enable_bit_reg <= 1'b0;
      ecf_reg  <= 1'b0;
      src_reg  <= SRC_OSC_A;
      gie_reg  <= 1'b0;
      aie_reg  <= 1'b0;
    end else begin
      if (wr_cmode) begin
        watchdog_enable_bit_reg <= WB_DAT_I[`CA_CMODE_WATCHDOG_ENABLE_BIT];
        ecf_reg  <= WB_DAT_I[`CA_CMODE_ECF];
        src_reg  <= count_src_t'(WB_DAT_I[`CA_CMODE_SEL_HI:`CA_CMODE_SEL_LO]);
      end
      if (wr_ien) begin
        gie_reg <= WB_DAT_I[`CA_IEN_GLOBAL];
        aie_reg <= WB_DAT_I[`CA_IEN_ARRAY];
      end
    end
  end

  // ==========================================================
  // Watchdog on module 4 and interrupt gating
  // Only module 4 can reset the device; the others just flag
  wire logic wd_armed = watchdog_enable_bit_reg & mode_reg[`CA_WD_MODULE][`CA_MM_COMPARATOR_ENABLE]
                      & mode_reg[`CA_WD_MODULE][`CA_MM_MAT];
  wire logic wd_fire  = wd_armed & match[`CA_WD_MODULE];

  // Internal reset pulse only; no external pin is driven
  // Registered so the reset pulse is free of decode glitches
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wd_reg <= 1'b0;
    end else begin
      wd_reg <= wd_fire;
    end
  end

  assign WD_RESET = wd_reg;
  wire logic irq_src = (|flag_irq) | (ovf_reg & ecf_reg);
  assign IRQ = gie_reg & aie_reg & irq_src;

  // ==========================================================
  // Read mux
  logic [31:0] rd_mux;
  wire  [2:0]  ms = mod_ok ? mod_sel : 3'h0;

  // Select read data; unmapped reads return zero
  // Registered below so the data stands with the ack
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[`CA_CTRL_OVF]   = ovf_reg;
      rd_mux[`CA_CTRL_RUN]   = run_reg;
      rd_mux[NUM_MOD-1:0]    = flag_reg;
    end else if (hit_cmode) begin
      rd_mux[`CA_CMODE_WATCHDOG_ENABLE_BIT] = watchdog_enable_bit_reg;
      rd_mux[`CA_CMODE_SEL_HI:`CA_CMODE_SEL_LO] = src_reg;
      rd_mux[`CA_CMODE_ECF]  = ecf_reg;
    end else if (hit_cntl) begin
      rd_mux[7:0] = cnt_reg[7:0];
    end else if (hit_cnth) begin
      rd_mux[7:0] = cnt_reg[15:8];
    end else if (hit_ien) begin
      rd_mux[`CA_IEN_GLOBAL] = gie_reg;
      rd_mux[`CA_IEN_ARRAY]  = aie_reg;
    end else if (mod_ok && grp_mode) begin
      rd_mux[7:0] = mode_reg[ms];
    end else if (mod_ok && grp_capl) begin
      rd_mux[7:0] = capl_reg[ms];
    end else if (mod_ok && grp_caph) begin
      rd_mux[7:0] = caph_reg[ms];
    end
  end

  // ==========================================================
  // Bus acknowledge, one wait state
  // Ack falls after one cycle so a held request is not taken twice
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg  <= bus_req & ~ack_reg;
      rdat_reg <= rd_mux;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdat_reg;

endmodule

// ==== verification/ca_pin_board.sv ====
`timescale 1ns/100ps
// ====
// Count sources on the board
module ca_pin_board (
  input  wire logic CLK,          // Clock
  output logic      TIMER0_OVF,   // Timer tick
  output logic      EXT_COUNT_IN  // Count pin, idles high
);
  // Idle levels
  initial begin
    TIMER0_OVF   = 1'b0;
    EXT_COUNT_IN = 1'b1;
  end
  // Timer ticks, one cycle each
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge CLK) TIMER0_OVF <= 1'b1;
      @(posedge CLK) TIMER0_OVF <= 1'b0;
    end
    repeat (4) @(posedge CLK);
    @(negedge CLK);
  endtask
  // Pin falls, slower than a quarter clock
  task automatic ext(input int n);
    repeat (n) begin
      repeat (4) @(posedge CLK);
      EXT_COUNT_IN <= 1'b0;
      repeat (4) @(posedge CLK);
      EXT_COUNT_IN <= 1'b1;
    end
    repeat (6) @(posedge CLK);
    @(negedge CLK);
  endtask
endmodule

// ==== verification/ca_props.sv ====
`timescale 1ns/100ps
// ====
// Port checker
module ca_props
  import ca_pkg::*;
#(
  parameter int NUM_MOD = 5
) (
  input wire logic               CLK,                // Clock
  input wire logic               RST_N,              // Reset
  input wire logic               WB_CYC_I,           // Cycle
  input wire logic               WB_STB_I,           // Strobe
  input wire logic               WB_WE_I,            // Write
  input wire logic [7:0]         WB_ADR_I,           // Address
  input wire logic [3:0]         WB_SEL_I,           // Selects
  input wire logic [31:0]        WB_DAT_I,           // Write data
  input wire logic [31:0]        WB_DAT_O,           // Read data
  input wire logic               WB_ACK_O,           // Ack
  input wire logic               TIMER0_OVF,         // Timer tick
  input wire logic               EXT_COUNT_IN,       // Count pin
  input wire logic [NUM_MOD-1:0] MODULE_COMPARE_PIN, // Pins
  input wire logic [NUM_MOD-1:0] MODULE_COMPARE_OE,  // Enables
  input wire logic               IRQ,                // Request
  input wire logic               WD_RESET            // Reset pulse
);
  logic [1:0] ien_reg;
  logic       watchdog_enable_bit_reg;
  logic [2:0] wa_reg;
  logic [7:0] wd_reg;
  wire        wr_ack = WB_ACK_O & WB_WE_I & WB_SEL_I[0];
  // Last bus address and data
  always_ff @(posedge CLK) begin
    wa_reg <= WB_ADR_I[4:2];
    wd_reg <= WB_DAT_I[7:0];
  end
  // Shadow of enable bits
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ien_reg  <= 2'h0;
      watchdog_enable_bit_reg <= 1'b0;
    end else if (wr_ack && WB_ADR_I == 8'h10) begin
      ien_reg <= WB_DAT_I[7:6];
    end else if (wr_ack && WB_ADR_I == 8'h04) begin
      watchdog_enable_bit_reg <= WB_DAT_I[6];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held too long");
  a_ack_answer: assert property ($rose(WB_STB_I) && WB_CYC_I |=> WB_ACK_O)
    else $error("ack missing");
  a_ack_cause: assert property (WB_ACK_O |-> $past(WB_STB_I) && $past(WB_CYC_I))
    else $error("ack without request");
  a_read_upper: assert property (WB_ACK_O && !WB_WE_I |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper read bits set");
  a_irq_gated: assert property (IRQ |-> &ien_reg)
    else $error("request while disabled");
  a_wd_pulse: assert property (WD_RESET |=> !WD_RESET)
    else $error("reset pulse too long");
  a_wd_enable: assert property (WD_RESET |-> watchdog_enable_bit_reg || $past(watchdog_enable_bit_reg))
    else $error("reset while disabled");
  a_oe_mode: assert property (wr_ack && WB_ADR_I[7:5] == 3'h1 && WB_ADR_I[4:2] < 3'h5
    |=> MODULE_COMPARE_OE[wa_reg] == (wd_reg[6] & (wd_reg[1] | wd_reg[3] & wd_reg[2])))
    else $error("enable not per mode");
endmodule
bind counter_array_compare_pwm_watchdog ca_props #(.NUM_MOD(NUM_MOD)) i_ca_props (
  .CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .TIMER0_OVF(TIMER0_OVF),
  .EXT_COUNT_IN(EXT_COUNT_IN), .MODULE_COMPARE_PIN(MODULE_COMPARE_PIN),
  .MODULE_COMPARE_OE(MODULE_COMPARE_OE), .IRQ(IRQ), .WD_RESET(WD_RESET));

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
// ====
// Bench
module tb_top import ca_pkg::*;;
  logic        CLK = 0, RST_N = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h00, rv;
  logic [3:0]  sel = 4'h1;
  logic [31:0] dat = 32'h0, dat_o;
  logic        ack, ovf, ext, irq, wdr;
  logic [4:0]  pins, oe;
  int          err_total = 0, compares = 0, cycles = 0, wd_seen = 0;
  counter_array_compare_pwm_watchdog #(.NUM_MOD(5)) i_counter_array_compare_pwm_watchdog (
    .CLK(CLK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .TIMER0_OVF(ovf), .EXT_COUNT_IN(ext), .MODULE_COMPARE_PIN(pins),
    .MODULE_COMPARE_OE(oe), .IRQ(irq), .WD_RESET(wdr));
  ca_pin_board i_ca_pin_board (.CLK(CLK), .TIMER0_OVF(ovf), .EXT_COUNT_IN(ext));
  always #10 CLK = ~CLK;
  // Reset pulses and timeout
  always @(posedge CLK) begin
    cycles++;
    if (wdr === 1'b1) wd_seen++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    @(posedge CLK);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {4{d}}; sel <= s;
    do @(posedge CLK); while (ack !== 1'b1);
    rv = dat_o[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(negedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'h1);
    chk(n, e, rv);
  endtask
  task automatic preset(input logic [7:0] lo);
    wr(8'h0C, 8'h00);
    wr(8'h08, lo);
  endtask
  // Test sequence
  initial begin
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    rchk("control", 8'h00, 8'h00);
    wr(8'hF0, 8'hFF);
    rchk("unmapped", 8'hF0, 8'h00);
    bus(1'b1, 8'h40, 8'h55, 4'hE);
    rchk("sel refused", 8'h40, 8'h00);
    chk("pins", 8'h1F, {3'h0, pins});
    $display("test reset done");
    wr(8'h04, {5'h0, SRC_TMR0, 1'b0});
    preset(8'h00);
    wr(8'h00, 8'h40);
    i_ca_pin_board.tick(5);
    rchk("timer count", 8'h08, 8'h05);
    wr(8'h00, 8'h00);
    i_ca_pin_board.tick(3);
    rchk("stopped count", 8'h08, 8'h05);
    wr(8'h04, {5'h0, SRC_EXTPIN, 1'b0});
    preset(8'h00);
    wr(8'h00, 8'h40);
    i_ca_pin_board.ext(4);
    rchk("pin count", 8'h08, 8'h04);
    for (int c = 0; c < 2; c++) begin
      wr(8'h04, {5'h0, c[1:0], 1'b0});
      preset(8'h00);
      wr(8'h00, 8'h40);
      repeat (60) @(posedge CLK);
      wr(8'h00, 8'h00);
      bus(1'b0, 8'h08, 8'h00, 4'h1);
      chk("osc count", 8'h01, {7'h0, rv >= 8'h09 && rv <= 8'h0B});
    end
    $display("test count done");
    wr(8'h04, {5'h0, SRC_TMR0, 1'b0});
    preset(8'h00);
    wr(8'h40, 8'h08); wr(8'h60, 8'h00); wr(8'h20, 8'h4D);
    wr(8'h44, 8'h08); wr(8'h64, 8'h00); wr(8'h24, 8'h0C);
    wr(8'h00, 8'h40);
    i_ca_pin_board.tick(8);
    chk("toggle pins", 8'h02, {6'h0, pins[1:0]});
    rchk("flags", 8'h00, 8'h41);
    wr(8'h10, 8'h80); chk("irq global", 8'h00, {7'h0, irq});
    wr(8'h10, 8'h40); chk("irq array", 8'h00, {7'h0, irq});
    wr(8'h10, 8'hC0); chk("irq both", 8'h01, {7'h0, irq});
    wr(8'h00, 8'h41); rchk("flag kept", 8'h00, 8'h41);
    wr(8'h00, 8'h40); rchk("flag clear", 8'h00, 8'h40);
    chk("irq off", 8'h00, {7'h0, irq});
    $display("test toggle done");
    wr(8'h48, 8'h80); wr(8'h68, 8'h40); wr(8'h28, 8'h42); wr(8'h2C, 8'h02);
    chk("enables", 8'h05, {3'h0, oe});
    preset(8'h7E);
    i_ca_pin_board.tick(1); chk("pulse low", 8'h00, {7'h0, pins[2]});
    i_ca_pin_board.tick(1); chk("pulse high", 8'h01, {7'h0, pins[2]});
    preset(8'hFF);
    i_ca_pin_board.tick(1);
    rchk("reload", 8'h48, 8'h40);
    chk("pulse new", 8'h00, {7'h0, pins[2]});
    $display("test pulse done");
    wr(8'h50, 8'h10); wr(8'h70, 8'h00);
    preset(8'h0C);
    wr(8'h04, 8'h44); wr(8'h30, 8'h48);
    i_ca_pin_board.tick(4); chk("wd reset", 8'h01, wd_seen[7:0]);
    wr(8'h50, 8'h30);
    i_ca_pin_board.tick(4); chk("wd held", 8'h01, wd_seen[7:0]);
    wr(8'h04, 8'h04); wr(8'h50, 8'h18);
    i_ca_pin_board.tick(4); chk("wd off", 8'h01, wd_seen[7:0]);
    wr(8'h04, 8'h44); wr(8'h50, 8'h1C);
    i_ca_pin_board.tick(4); chk("wd again", 8'h02, wd_seen[7:0]);
    wr(8'h30, 8'h40); wr(8'h50, 8'h20);
    i_ca_pin_board.tick(4); chk("wd no match", 8'h02, wd_seen[7:0]);
    $display("test watchdog done");
    wr(8'h00, 8'h40); wr(8'h0C, 8'hFF); wr(8'h08, 8'hFF);
    i_ca_pin_board.tick(1);
    rchk("overflow", 8'h00, 8'hC0);
    wr(8'h04, 8'h05); chk("irq overflow", 8'h01, {7'h0, irq});
    wr(8'h00, 8'h40); chk("irq cleared", 8'h00, {7'h0, irq});
    $display("test overflow done");
    give_verdict;
  end
endmodule
